/* timer_pkg.sv */
// Constants, types and state layout shared by the dual timer/counter pair
package timer_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam int          ADDR_W      = 12;
	localparam logic [9:0]  IDX_ISTAT   = 10'h080;
	localparam logic [9:0]  IDX_IMASK   = 10'h081;
	localparam logic [9:0]  IDX_CTRL    = 10'h088;
	localparam logic [9:0]  IDX_MODE    = 10'h089;
	localparam logic [9:0]  IDX_TL0     = 10'h08A;
	localparam logic [9:0]  IDX_TL1     = 10'h08B;
	localparam logic [9:0]  IDX_TH0     = 10'h08C;
	localparam logic [9:0]  IDX_TH1     = 10'h08D;
	localparam logic [9:0]  IDX_CLK     = 10'h08E;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int          MODE_T1_GATE = 7;
	localparam int          MODE_T1_CT   = 6;
	localparam int          MODE_T1_M    = 4;
	localparam int          MODE_T0_GATE = 3;
	localparam int          MODE_T0_CT   = 2;
	localparam int          MODE_T0_M    = 0;
	localparam int          CLK_PWM      = 6;
	localparam int          CLK_T1M      = 4;
	localparam int          CLK_T0M      = 3;
	localparam int          CLK_CLOCK_OUTPUT_ENABLE    = 1;
	localparam logic [7:0]  CLK_WR_MASK  = 8'h5A;
	localparam int          CTRL_F1      = 7;
	localparam int          CTRL_R1      = 6;
	localparam int          CTRL_F0      = 5;
	localparam int          CTRL_R0      = 4;
	localparam int          IRQ_T0       = 0;
	localparam int          IRQ_T1       = 1;
	localparam logic [7:0]  REG_RESET    = 8'h00;

	// ****************************************************************
	// Timing and pin synchroniser
	// ****************************************************************
	localparam int          PRESC_DIV    = 12;
	localparam logic [3:0]  PRESC_LAST   = 4'(PRESC_DIV - 1);
	localparam int          SYNC_STAGES  = 3;
	localparam int          PIN_T0       = 0;
	localparam int          PIN_T1       = 1;
	localparam int          PIN_EXTERNAL_INTERRUPT0_PIN     = 2;
	localparam int          PIN_EXTERNAL_INTERRUPT1_PIN     = 3;
	localparam int          PIN_COUNT    = 4;

	typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} timer_mode_e;

	typedef struct packed {
		logic       ovf;
		logic [7:0] tl;
		logic [7:0] th;
	} step_s;

	typedef struct packed {
		logic [7:0]                              mode_sel;
		logic [7:0]                              tl0;
		logic [7:0]                              th0;
		logic [7:0]                              tl1;
		logic [7:0]                              th1;
		logic [7:0]                              clk_ctl;
		logic                                    run0;
		logic                                    run1;
		logic                                    flag0;
		logic                                    flag1;
		logic [1:0]                              istat;
		logic [1:0]                              imask;
		logic                                    ack;
		logic [31:0]                             rdata;
		logic [3:0]                              presc;
		logic [PIN_COUNT-1:0][SYNC_STAGES-1:0]   sync;
		logic [PIN_COUNT-1:0]                    filt;
		logic                                    pwm_tick;
	} state_s;

	localparam state_s STATE_RESET = '0;

endpackage

/* dual_timer_counter_pair.sv */
// Dual timer/counter pair with Wishbone register access
// How it works
// - Timer 1 counts with run bit; qualify bit also demands interrupt 1 pin high.
// - Timer 0 counts with run bit; qualify bit also demands interrupt 0 pin high.
// - Timer 1 source: internal clock, or falling edges of its count pin.
// - Timer 0 source: internal clock, or falling edges of its count pin.
// - Timer 1 modes: 13-bit, 16-bit, 8-bit reload from high byte, halted.
// - Timer 0 modes: 13-bit, 16-bit, 8-bit with low byte reloaded from high.
// - Timer 0 split mode: low byte and high byte count as separate 8-bit timers.
// - Timer 0 count lives in readable, writable low and high bytes.
// - Timer 1 count lives in readable, writable low and high bytes.
// - Timer 1 internal clock is system clock over twelve, or undivided.
// - Timer 0 internal clock is system clock over twelve, or undivided.
// - PWM clock is system clock, or timer 1 overflow events.
// - Clock output pin carries system clock only when enabled.
// - Clearing a run bit freezes the count until resumed or rewritten.
// - Overflow sets the flag; service entry clears it; software may write it.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_pair (
	input  wire logic        clk_i,                     // System clock
	input  wire logic        rst_i,                     // Synchronous reset, high
	input  wire logic        cyc_i,                     // Wishbone cycle
	input  wire logic        stb_i,                     // Wishbone strobe
	input  wire logic        we_i,                      // Wishbone write enable
	input  wire logic [11:0] adr_i,                     // Wishbone byte address
	input  wire logic [3:0]  sel_i,                     // Wishbone byte selects
	input  wire logic [31:0] dat_i,                     // Wishbone write data
	output logic      [31:0] dat_o,                     // Wishbone read data
	output logic             ack_o,                     // Wishbone acknowledge
	input  wire logic        timer0_count_pin_i,        // External count, timer 0
	input  wire logic        timer1_count_pin_i,        // External count, timer 1
	input  wire logic        external_interrupt0_pin_i, // Gate pin, timer 0
	input  wire logic        external_interrupt1_pin_i, // Gate pin, timer 1
	input  wire logic        timer0_isr_entry_i,        // Timer 0 service entered
	input  wire logic        timer1_isr_entry_i,        // Timer 1 service entered
	output logic             irq_o,                     // Interrupt, level high
	output logic             pwm_clk_tick_o,            // PWM clock tick
	output logic             clock_output_pin_o         // System clock output
);

	// ****************************************************************
	// State
	// ****************************************************************
	timer_pkg::state_s   s_reg;
	timer_pkg::state_s   s_next;

	logic [9:0]          idx;
	logic                req;
	logic                fire;
	logic                wr;
	logic                rd;
	logic [7:0]          wbyte;
	logic [7:0]          rd_mux;
	logic [timer_pkg::PIN_COUNT-1:0] pins;
	logic [timer_pkg::PIN_COUNT-1:0] settle;
	logic [timer_pkg::PIN_COUNT-1:0] fall;
	logic                tick12;
	logic                int_tick0;
	logic                int_tick1;
	logic                inc0;
	logic                inc1;
	logic                inc_th0;
	logic                split0;
	logic                ev0;
	logic                ev1;
	logic                t1_ovf;
	logic                th0_ovf;
	logic                wr_t0;
	logic                wr_t1;
	timer_pkg::step_s    st0;
	timer_pkg::step_s    st1;

	// ****************************************************************
	// Count step for one timer in the given mode
	// ****************************************************************
	function automatic timer_pkg::step_s count_step(
		input timer_pkg::timer_mode_e mode,
		input logic [7:0]             tl,
		input logic [7:0]             th,
		input logic                   inc
	);
		timer_pkg::step_s r;
		logic [12:0]      c13;
		logic [15:0]      c16;
		r.ovf = 1'b0;
		r.tl  = tl;
		r.th  = th;
		c13   = {th, tl[4:0]} + 13'h0001;
		c16   = {th, tl} + 16'h0001;
		if (inc) begin
			case (mode)
				timer_pkg::MODE_13BIT: begin
					r.ovf = &{th, tl[4:0]};
					{r.th, r.tl[4:0]} = c13;
				end
				timer_pkg::MODE_16BIT: begin
					r.ovf = &{th, tl};
					{r.th, r.tl} = c16;
				end
				timer_pkg::MODE_RELOAD: begin
					r.ovf = &tl;
					r.tl  = (&tl) ? th : tl + 8'h01;
				end
				default: begin
					r.ovf = &tl;
					r.tl  = tl + 8'h01;
				end
			endcase
		end
		return r;
	endfunction

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	assign idx   = adr_i[11:2];
	assign req   = cyc_i & stb_i & ~s_reg.ack;
	assign fire  = cyc_i & stb_i & s_reg.ack;
	assign wr    = fire & we_i & sel_i[0];
	assign rd    = fire & ~we_i;
	assign wbyte = dat_i[7:0];
	assign wr_t0 = wr & ((idx == timer_pkg::IDX_TL0) | (idx == timer_pkg::IDX_TH0) |
	               (idx == timer_pkg::IDX_MODE) | (idx == timer_pkg::IDX_CTRL) | (idx == timer_pkg::IDX_CLK));
	assign wr_t1 = wr & ((idx == timer_pkg::IDX_TL1) | (idx == timer_pkg::IDX_TH1) |
	               (idx == timer_pkg::IDX_MODE) | (idx == timer_pkg::IDX_CTRL) | (idx == timer_pkg::IDX_CLK));

	always_comb begin
		case (idx)
			timer_pkg::IDX_ISTAT: rd_mux = {6'h00, s_reg.istat};
			timer_pkg::IDX_IMASK: rd_mux = {6'h00, s_reg.imask};
			timer_pkg::IDX_CTRL:  rd_mux = {s_reg.flag1, s_reg.run1, s_reg.flag0, s_reg.run0, 4'h0};
			timer_pkg::IDX_MODE:  rd_mux = s_reg.mode_sel;
			timer_pkg::IDX_TL0:   rd_mux = s_reg.tl0;
			timer_pkg::IDX_TH0:   rd_mux = s_reg.th0;
			timer_pkg::IDX_TL1:   rd_mux = s_reg.tl1;
			timer_pkg::IDX_TH1:   rd_mux = s_reg.th1;
			timer_pkg::IDX_CLK:   rd_mux = s_reg.clk_ctl;
			default:              rd_mux = 8'h00;
		endcase
	end

	// ****************************************************************
	// Pin edges and clock sources
	// ****************************************************************
	assign pins = {external_interrupt1_pin_i, external_interrupt0_pin_i, timer1_count_pin_i, timer0_count_pin_i};

	// A change counts once stages two and three agree
	always_comb begin
		for (int k = 0; k < timer_pkg::PIN_COUNT; k++) begin
			settle[k] = s_reg.sync[k][1] == s_reg.sync[k][2];
			fall[k]   = s_reg.filt[k] & settle[k] & ~s_reg.sync[k][2];
		end
	end

	assign tick12    = s_reg.presc == timer_pkg::PRESC_LAST;
	assign int_tick0 = s_reg.clk_ctl[timer_pkg::CLK_T0M] ? 1'b1 : tick12;
	assign int_tick1 = s_reg.clk_ctl[timer_pkg::CLK_T1M] ? 1'b1 : tick12;
	assign split0    = s_reg.mode_sel[timer_pkg::MODE_T0_M +: 2] == 2'(timer_pkg::MODE_SPLIT);

	assign inc0 = s_reg.run0
	            & (~s_reg.mode_sel[timer_pkg::MODE_T0_GATE] | s_reg.filt[timer_pkg::PIN_EXTERNAL_INTERRUPT0_PIN])
	            & (s_reg.mode_sel[timer_pkg::MODE_T0_CT] ? fall[timer_pkg::PIN_T0] : int_tick0);
	assign inc1 = s_reg.run1
	            & (s_reg.mode_sel[timer_pkg::MODE_T1_M +: 2] != 2'(timer_pkg::MODE_SPLIT))
	            & (~s_reg.mode_sel[timer_pkg::MODE_T1_GATE] | s_reg.filt[timer_pkg::PIN_EXTERNAL_INTERRUPT1_PIN])
	            & (s_reg.mode_sel[timer_pkg::MODE_T1_CT] ? fall[timer_pkg::PIN_T1] : int_tick1);
	assign inc_th0 = split0 & s_reg.run1 & int_tick0;

	assign st0 = count_step(timer_pkg::timer_mode_e'(s_reg.mode_sel[timer_pkg::MODE_T0_M +: 2]),
	                        s_reg.tl0, s_reg.th0, inc0);
	assign st1 = count_step(timer_pkg::timer_mode_e'(s_reg.mode_sel[timer_pkg::MODE_T1_M +: 2]),
	                        s_reg.tl1, s_reg.th1, inc1);

	assign th0_ovf = inc_th0 & (&s_reg.th0);
	assign t1_ovf  = st1.ovf;
	assign ev0     = st0.ovf;
	assign ev1     = split0 ? th0_ovf : t1_ovf;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_next = s_reg;

		s_next.ack = req;
		if (req) begin
			s_next.rdata = {24'h000000, rd_mux};
		end

		for (int k = 0; k < timer_pkg::PIN_COUNT; k++) begin
			s_next.sync[k] = {s_reg.sync[k][1:0], pins[k]};
			if (settle[k]) begin
				s_next.filt[k] = s_reg.sync[k][2];
			end
		end

		s_next.presc = tick12 ? 4'h0 : s_reg.presc + 4'h1;

		// Counting
		s_next.tl0 = st0.tl;
		s_next.th0 = split0 ? (inc_th0 ? s_reg.th0 + 8'h01 : s_reg.th0) : st0.th;
		s_next.tl1 = st1.tl;
		s_next.th1 = st1.th;

		// Flags: service entry clears, software writes, overflow wins
		if (timer0_isr_entry_i) begin
			s_next.flag0 = 1'b0;
		end
		if (timer1_isr_entry_i) begin
			s_next.flag1 = 1'b0;
		end

		// Register writes override counting in the same cycle
		if (wr) begin
			case (idx)
				timer_pkg::IDX_IMASK: s_next.imask = wbyte[1:0];
				timer_pkg::IDX_CTRL: begin
					s_next.flag1 = wbyte[timer_pkg::CTRL_F1];
					s_next.run1  = wbyte[timer_pkg::CTRL_R1];
					s_next.flag0 = wbyte[timer_pkg::CTRL_F0];
					s_next.run0  = wbyte[timer_pkg::CTRL_R0];
				end
				timer_pkg::IDX_MODE:  s_next.mode_sel = wbyte;
				timer_pkg::IDX_TL0:   s_next.tl0 = wbyte;
				timer_pkg::IDX_TH0:   s_next.th0 = wbyte;
				timer_pkg::IDX_TL1:   s_next.tl1 = wbyte;
				timer_pkg::IDX_TH1:   s_next.th1 = wbyte;
				timer_pkg::IDX_CLK:   s_next.clk_ctl = wbyte & timer_pkg::CLK_WR_MASK;
				default: begin
				end
			endcase
		end

		if (ev0) begin
			s_next.flag0 = 1'b1;
		end
		if (ev1) begin
			s_next.flag1 = 1'b1;
		end

		// Status clears only the bits that the read returned
		if (rd && idx == timer_pkg::IDX_ISTAT) begin
			s_next.istat = s_reg.istat & ~s_reg.rdata[1:0];
		end
		s_next.istat[timer_pkg::IRQ_T0] = s_next.istat[timer_pkg::IRQ_T0] | ev0;
		s_next.istat[timer_pkg::IRQ_T1] = s_next.istat[timer_pkg::IRQ_T1] | ev1;

		s_next.pwm_tick = s_reg.clk_ctl[timer_pkg::CLK_PWM] ? t1_ovf : 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= timer_pkg::STATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign dat_o              = s_reg.rdata;
	assign ack_o              = s_reg.ack;
	assign irq_o              = |(s_reg.istat & s_reg.imask);
	assign pwm_clk_tick_o     = s_reg.pwm_tick;
	assign clock_output_pin_o = s_reg.clk_ctl[timer_pkg::CLK_CLOCK_OUTPUT_ENABLE] & clk_i;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_single_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	prescale_period_a: assert property (tick12 |-> ##12 tick12)
		else $error("divide-by-twelve tick period wrong");
	prescale_gap_a: assert property (tick12 |=> !tick12 [*8])
		else $error("divide-by-twelve tick too early");
	stop_holds_a: assert property ((!s_reg.run0 && !split0 && !wr_t0) |=> $stable({s_reg.tl0, s_reg.th0}))
		else $error("stopped timer 0 changed");
	gate_holds_a: assert property ((s_reg.mode_sel[timer_pkg::MODE_T0_GATE] && !s_reg.filt[timer_pkg::PIN_EXTERNAL_INTERRUPT0_PIN]
		&& !wr_t0) |=> $stable(s_reg.tl0))
		else $error("gated timer 0 low byte advanced");
	gate1_holds_a: assert property ((s_reg.mode_sel[timer_pkg::MODE_T1_GATE] && !s_reg.filt[timer_pkg::PIN_EXTERNAL_INTERRUPT1_PIN]
		&& !wr_t1) |=> $stable({s_reg.tl1, s_reg.th1}))
		else $error("gated timer 1 advanced");
	halt_mode1_a: assert property ((s_reg.mode_sel[timer_pkg::MODE_T1_M +: 2] == 2'b11 && !wr_t1)
		|=> $stable({s_reg.tl1, s_reg.th1}))
		else $error("timer 1 counted while halted");
	reload_low_a: assert property ((s_reg.mode_sel[1:0] == 2'b10 && inc0 && s_reg.tl0 == 8'hFF && !wr_t0)
		|=> s_reg.tl0 == $past(s_reg.th0) && s_reg.flag0)
		else $error("timer 0 reload or flag missing");
	wrap16_a: assert property ((s_reg.mode_sel[1:0] == 2'b01 && inc0 && !wr_t0)
		|=> {s_reg.th0, s_reg.tl0} == $past({s_reg.th0, s_reg.tl0}) + 16'h0001)
		else $error("timer 0 16-bit step wrong");
	wrap13_a: assert property ((s_reg.mode_sel[1:0] == 2'b00 && inc0 && !wr_t0)
		|=> s_reg.tl0[7:5] == $past(s_reg.tl0[7:5])
		&& {s_reg.th0, s_reg.tl0[4:0]} == $past({s_reg.th0, s_reg.tl0[4:0]}) + 13'h0001)
		else $error("timer 0 13-bit step wrong");
	count_edge_a: assert property ((s_reg.mode_sel[timer_pkg::MODE_T0_CT] && !fall[timer_pkg::PIN_T0] && !wr_t0
		&& !split0) |=> $stable({s_reg.tl0, s_reg.th0}))
		else $error("counter mode advanced without a falling edge");
	count_edge1_a: assert property ((s_reg.mode_sel[timer_pkg::MODE_T1_CT] && !fall[timer_pkg::PIN_T1] && !wr_t1)
		|=> $stable({s_reg.tl1, s_reg.th1}))
		else $error("timer 1 counter mode advanced without an edge");
	split_high_a: assert property ((split0 && s_reg.run1 && s_reg.th0 == 8'hFF && int_tick0 && !wr_t0)
		|=> s_reg.th0 == 8'h00 && s_reg.flag1)
		else $error("split high byte overflow wrong");
	split_low_a: assert property ((split0 && inc0 && !wr_t0) |=> s_reg.tl0 == $past(s_reg.tl0) + 8'h01)
		else $error("split low byte step wrong");
	flag_clear_a: assert property ((timer0_isr_entry_i && !ev0 && !wr) |=> !s_reg.flag0)
		else $error("service entry did not clear timer 0 flag");
	count_write_a: assert property ((wr && idx == timer_pkg::IDX_TH1) |=> s_reg.th1 == $past(wbyte))
		else $error("timer 1 high byte write lost");
	count_write0_a: assert property ((wr && idx == timer_pkg::IDX_TL0) |=> s_reg.tl0 == $past(wbyte))
		else $error("timer 0 low byte write lost");
	pwm_source_a: assert property ((s_reg.clk_ctl[timer_pkg::CLK_PWM]) |=> pwm_clk_tick_o == $past(t1_ovf))
		else $error("PWM tick does not follow timer 1 overflow");
	pwm_sys_a: assert property ((!s_reg.clk_ctl[timer_pkg::CLK_PWM]) |=> pwm_clk_tick_o)
		else $error("PWM tick missing on system clock");
	clk_out_off_a: assert property (!s_reg.clk_ctl[timer_pkg::CLK_CLOCK_OUTPUT_ENABLE] |-> !clock_output_pin_o)
		else $error("clock output active while disabled");

	ovf0_seen_c: cover property (ev0 && !split0);
	reload_seen_c: cover property (s_reg.mode_sel[1:0] == 2'b10 && ev0);
	split_seen_c: cover property (split0 && th0_ovf);
	edge_count_c: cover property (inc0 && s_reg.mode_sel[timer_pkg::MODE_T0_CT]);
	irq_read_c: cover property (irq_o ##1 (rd && idx == timer_pkg::IDX_ISTAT));

endmodule

`default_nettype wire

/* pin_source.sv */
// Model of the external count and gate pins
`timescale 1ns/1ps
`default_nettype none

module pin_source (
	input  wire logic       clk_i,  // System clock
	output logic      [3:0] pins_o  // Count and gate pins, idle high
);
	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	initial pins_o = 4'hF;

	// Each level held long enough to pass the pin synchroniser
	task automatic edges(input int p, input int n);
		repeat (n) begin
			@(posedge clk_i);
			pins_o[p] <= 1'b0;
			repeat (4) @(posedge clk_i);
			pins_o[p] <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
	endtask

	task automatic set(input int p, input logic v);
		@(posedge clk_i);
		pins_o[p] <= v;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire

/* dual_timer_counter_pair_bench.sv */
// Self-checking bench of the dual timer/counter pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %0t got %0h exp %0h", $time, a, e); end end

module dual_timer_counter_pair_bench;
	typedef struct packed {logic [9:0] i; logic [7:0] w; logic [7:0] e;} row_s;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] dat = 32'h0;
	logic        isr1 = 1'b0;
	logic [31:0] dat_o;
	logic        ack_o, irq_o, pwm, clko;
	logic [3:0]  pins;
	logic [7:0]  q;
	int          errors = 0;
	int          tests_run = 0;
	int          pulses = 0;
	int          p0 = 0;
	row_s        rows [8] = '{'{timer_pkg::IDX_MODE, 8'hA5, 8'hA5}, '{timer_pkg::IDX_TL0, 8'h3C, 8'h3C},
		'{timer_pkg::IDX_TL1, 8'hC3, 8'hC3}, '{timer_pkg::IDX_TH0, 8'h5A, 8'h5A},
		'{timer_pkg::IDX_TH1, 8'hA5, 8'hA5}, '{timer_pkg::IDX_CLK, 8'hFF, 8'h5A},
		'{timer_pkg::IDX_IMASK, 8'hFF, 8'h03}, '{10'h090, 8'hFF, 8'h00}};

	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) pulses <= pulses + int'(pwm === 1'b1);

	pin_source pin_u (.clk_i(clk_i), .pins_o(pins));

	dual_timer_counter_pair dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.timer0_count_pin_i(pins[timer_pkg::PIN_T0]), .timer1_count_pin_i(pins[timer_pkg::PIN_T1]),
		.external_interrupt0_pin_i(pins[timer_pkg::PIN_EXTERNAL_INTERRUPT0_PIN]),
		.external_interrupt1_pin_i(pins[timer_pkg::PIN_EXTERNAL_INTERRUPT1_PIN]), .timer0_isr_entry_i(isr1),
		.timer1_isr_entry_i(isr1), .irq_o(irq_o), .pwm_clk_tick_o(pwm), .clock_output_pin_o(clko));

	// ****************************************************************
	// Bus cycles and closing report
	// ****************************************************************
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			test_done();
		end else begin
			q = dat_o[7:0];
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
		end
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		wb(1'b1, i, d);
	endtask

	task automatic rd(input logic [9:0] i);
		wb(1'b0, i, 8'h00);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		`CHK(pwm, 1'b1)
		`CHK(clko, 1'b0)
		foreach (rows[k]) begin
			rd(rows[k].i);
			`CHK(q, timer_pkg::REG_RESET)
		end
		foreach (rows[k]) begin
			wr(rows[k].i, rows[k].w);
			rd(rows[k].i);
			`CHK(q, rows[k].e)
		end
		$display("registers done");
		wr(timer_pkg::IDX_CLK, 8'h02);
		@(posedge clk_i);
		#1;
		`CHK(clko, 1'b1)
		wr(timer_pkg::IDX_CLK, 8'h00);
		wr(timer_pkg::IDX_MODE, 8'h0D);
		wr(timer_pkg::IDX_TL0, 8'h00);
		wr(timer_pkg::IDX_CTRL, 8'h10);
		pin_u.edges(timer_pkg::PIN_T0, 5);
		rd(timer_pkg::IDX_TL0);
		`CHK(q, 8'h05)
		pin_u.set(timer_pkg::PIN_EXTERNAL_INTERRUPT0_PIN, 1'b0);
		pin_u.edges(timer_pkg::PIN_T0, 3);
		rd(timer_pkg::IDX_TL0);
		`CHK(q, 8'h05)
		pin_u.set(timer_pkg::PIN_EXTERNAL_INTERRUPT0_PIN, 1'b1);
		pin_u.edges(timer_pkg::PIN_T0, 3);
		rd(timer_pkg::IDX_TL0);
		`CHK(q, 8'h08)
		wr(timer_pkg::IDX_CTRL, 8'h00);
		pin_u.edges(timer_pkg::PIN_T0, 2);
		rd(timer_pkg::IDX_TL0);
		`CHK(q, 8'h08)
		$display("timer 0 pin count done");
		wr(timer_pkg::IDX_MODE, 8'hE0);
		wr(timer_pkg::IDX_CLK, 8'h40);
		wr(timer_pkg::IDX_TH1, 8'hFD);
		wr(timer_pkg::IDX_TL1, 8'hFE);
		wr(timer_pkg::IDX_IMASK, 8'h02);
		wr(timer_pkg::IDX_CTRL, 8'h40);
		p0 = pulses;
		pin_u.edges(timer_pkg::PIN_T1, 1);
		rd(timer_pkg::IDX_TL1);
		`CHK(q, 8'hFF)
		`CHK(irq_o, 1'b0)
		pin_u.edges(timer_pkg::PIN_T1, 1);
		rd(timer_pkg::IDX_TL1);
		`CHK(q, 8'hFD)
		rd(timer_pkg::IDX_CTRL);
		`CHK(q, 8'hC0)
		`CHK(irq_o, 1'b1)
		`CHK(pulses - p0, 1)
		rd(timer_pkg::IDX_ISTAT);
		`CHK(q, 8'h02)
		#1;
		`CHK(irq_o, 1'b0)
		@(posedge clk_i);
		isr1 <= 1'b1;
		@(posedge clk_i);
		isr1 <= 1'b0;
		rd(timer_pkg::IDX_CTRL);
		`CHK(q, 8'h40)
		pin_u.set(timer_pkg::PIN_EXTERNAL_INTERRUPT1_PIN, 1'b0);
		pin_u.edges(timer_pkg::PIN_T1, 1);
		rd(timer_pkg::IDX_TL1);
		`CHK(q, 8'hFD)
		$display("timer 1 reload done");
		wr(timer_pkg::IDX_CTRL, 8'h00);
		wr(timer_pkg::IDX_MODE, 8'h04);
		wr(timer_pkg::IDX_TL0, 8'hFF);
		wr(timer_pkg::IDX_TH0, 8'hFF);
		wr(timer_pkg::IDX_CTRL, 8'h10);
		pin_u.edges(timer_pkg::PIN_T0, 1);
		rd(timer_pkg::IDX_TL0);
		`CHK(q, 8'hE0)
		rd(timer_pkg::IDX_TH0);
		`CHK(q, 8'h00)
		rd(timer_pkg::IDX_CTRL);
		`CHK(q, 8'h30)
		$display("13-bit mode done");
		wr(timer_pkg::IDX_CTRL, 8'h00);
		wr(timer_pkg::IDX_MODE, 8'h07);
		wr(timer_pkg::IDX_CLK, 8'h08);
		wr(timer_pkg::IDX_TL0, 8'h00);
		wr(timer_pkg::IDX_TH0, 8'hF0);
		wr(timer_pkg::IDX_CTRL, 8'h40);
		repeat (40) @(posedge clk_i);
		rd(timer_pkg::IDX_CTRL);
		`CHK(q, 8'hC0)
		rd(timer_pkg::IDX_TL0);
		`CHK(q, 8'h00)
		$display("split mode done");
		wr(timer_pkg::IDX_CTRL, 8'h00);
		wr(timer_pkg::IDX_MODE, 8'h10);
		wr(timer_pkg::IDX_CLK, 8'h00);
		wr(timer_pkg::IDX_TL1, 8'h00);
		wr(timer_pkg::IDX_CTRL, 8'h40);
		repeat (240) @(posedge clk_i);
		wr(timer_pkg::IDX_CTRL, 8'h00);
		rd(timer_pkg::IDX_TL1);
		`CHK(q >= 8'd19 && q <= 8'd21, 1'b1)
		wr(timer_pkg::IDX_CLK, 8'h10);
		wr(timer_pkg::IDX_TL1, 8'h00);
		wr(timer_pkg::IDX_CTRL, 8'h40);
		repeat (100) @(posedge clk_i);
		wr(timer_pkg::IDX_CTRL, 8'h00);
		rd(timer_pkg::IDX_TL1);
		`CHK(q >= 8'd102 && q <= 8'd104, 1'b1)
		$display("clock mode done");
		test_done();
	end
endmodule

`default_nettype wire
